// ### ffc_top.sv
// Line sensor flat field correction stage with APB registers
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "ffc_defs.svh"

// ==========================================================
// Stream FIFO
module ffc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             empty_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = ~empty_r;
  assign out_data  = mem[rd_ptr_r];

  always_ff @(posedge pclk) begin
    if (ce && push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      empty_r  <= 1'b1;
      in_ready <= 1'b1;
    end else if (ce) begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      cnt_r    <= cnt_nxt;
      empty_r  <= (cnt_nxt == '0);
      in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule // ffc_fifo

// ==========================================================
// Correction stage
module ffc_top
  import ffc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensor line stream
  input  wire logic [11:0] pix_in_data,
  input  wire logic        pix_in_sol,
  input  wire logic        pix_in_eol,
  input  wire logic        pix_in_valid,
  output logic             pix_in_ready,
  // Corrected line stream
  output logic [11:0]      pix_out_data,
  output logic             pix_out_sol,
  output logic             pix_out_eol,
  output logic             pix_out_valid,
  input  wire logic        pix_out_ready
);
  localparam int PW = `FFC_PIX_W;
  localparam int CW = `FFC_COL_W;
  localparam int GW = `FFC_GAIN_W;

  // ========================================================
  // Storage: volatile sets, accumulators, flash banks
  logic [PW-1:0]         dark_mem   [`FFC_LINE_PIX];
  logic [GW-1:0]         gain_mem   [`FFC_LINE_PIX];
  logic [`FFC_ACC_W-1:0] acc_mem    [`FFC_LINE_PIX];
  logic [PW-1:0]         dark_flash [`FFC_FLASH_WORDS];
  logic [GW-1:0]         resp_flash [`FFC_FLASH_WORDS];

  ffc_state_e  st_r;
  ffc_state_e  st_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] roi_r;
  logic [5:0]  pend_r;
  logic [CW-1:0] col_r;
  logic [CW-1:0] copy_r;
  logic [9:0]  lines_r;
  logic [PW-1:0] black_r;
  logic [PW+1:0] ob_sum_r;
  logic        dark_valid_r;
  logic        resp_valid_r;
  logic [2:0]  gen_gain_r;
  logic [CW-1:0] roi_start_r;
  logic [6:0]  roi_width_r;
  logic [7:0]  tgt_lvl_r;
  logic [PW-1:0] auto_max_r;

  // ========================================================
  // APB decode
  wire        access   = psel & penable;
  wire        hit_ctrl = (paddr == `FFC_REG_CTRL);
  wire        hit_cmd  = (paddr == `FFC_REG_CMD);
  wire        hit_roi  = (paddr == `FFC_REG_ROI);
  wire        hit_stat = (paddr == `FFC_REG_STATUS);
  wire        hit_blk  = (paddr == `FFC_REG_BLACK);
  wire        hit      = hit_ctrl | hit_cmd | hit_roi | hit_stat | hit_blk;
  wire        wr_en    = access & pready & pwrite & hit;
  wire [5:0]  cmd_set  = (wr_en & hit_cmd) ? pwdata[5:0] : 6'h00;
  wire [31:0] status_w = {9'h000, gen_gain_r, lines_r, resp_valid_r,
                          dark_valid_r, st_r, ~st_r[0]};
  wire [31:0] rd_mux   = hit_ctrl ? ctrl_r :
                         hit_roi  ? roi_r :
                         hit_stat ? status_w :
                         hit_blk  ? {20'h00000, black_r} : 32'h0000_0000;

  wire       clamp_en  = ctrl_r[`FFC_CTRL_CLAMP];
  wire       resp_en   = ctrl_r[`FFC_CTRL_RESP];
  wire       auto_sel  = ctrl_r[`FFC_CTRL_AUTO];
  wire [2:0] slot_sel  = ctrl_r[`FFC_CTRL_SLOT +: 3];
  wire [7:0] man_level = ctrl_r[`FFC_CTRL_TGT +: 8];
  wire [2:0] again_sel = ctrl_r[`FFC_CTRL_AGAIN +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      ctrl_r  <= `FFC_CTRL_RST;
      roi_r   <= `FFC_ROI_RST;
    end else if (ce) begin
      // One wait state; data and error latched on the same edge that raises pready
      pready  <= access & ~pready;
      if (access && !pready) begin
        pslverr <= ~hit;
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr_en && hit_ctrl) begin
        ctrl_r <= pwdata & `FFC_CTRL_MASK;
      end
      if (wr_en && hit_roi) begin
        roi_r <= pwdata & `FFC_ROI_MASK;
      end
    end
  end

  // ========================================================
  // Stream input buffer
  logic [13:0] f_word;
  logic        f_valid;
  wire         f_ready = ~pix_out_valid | pix_out_ready;
  wire         f_beat  = f_valid & f_ready;
  wire [PW-1:0] f_data = f_word[PW-1:0];
  wire         f_sol   = f_word[PW];
  wire         f_eol   = f_word[PW+1];

  ffc_fifo #(
    .WIDTH (14),
    .DEPTH (`FFC_FIFO_DEPTH),
    .AW    (`FFC_FIFO_AW)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_data   ({pix_in_eol, pix_in_sol, pix_in_data}),
    .in_valid  (pix_in_valid),
    .in_ready  (pix_in_ready),
    .out_data  (f_word),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // ========================================================
  // Command sequencing
  wire idle      = (st_r == FFC_IDLE);
  wire no_copy   = ~(pend_r[`FFC_CMD_DSAVE] | pend_r[`FFC_CMD_DLOAD] |
                     pend_r[`FFC_CMD_RSAVE] | pend_r[`FFC_CMD_RLOAD]);
  wire sol_beat  = f_beat & f_sol;
  wire go_ds     = idle & pend_r[`FFC_CMD_DSAVE];
  wire go_dl     = idle & pend_r[`FFC_CMD_DLOAD] & ~go_ds;
  wire go_rs     = idle & pend_r[`FFC_CMD_RSAVE] & ~go_ds & ~go_dl;
  wire go_rl     = idle & pend_r[`FFC_CMD_RLOAD] & ~go_ds & ~go_dl & ~go_rs;
  wire go_dg     = idle & pend_r[`FFC_CMD_DGEN] & no_copy & sol_beat;
  wire go_rg     = idle & pend_r[`FFC_CMD_RGEN] & no_copy & sol_beat &
                   ~go_dg;
  wire [5:0] taken = {go_rl, go_rs, go_rg, go_dl, go_ds, go_dg};
  wire copy_last = (copy_r == CW'(`FFC_LINE_PIX - 1));
  wire gen_dark  = (st_r == FFC_DGEN) | go_dg;
  wire gen_resp  = (st_r == FFC_RGEN) | go_rg;
  wire gen_act   = gen_dark | gen_resp;
  wire line_last = (lines_r == `FFC_GEN_LAST) & ~go_dg & ~go_rg;
  wire gen_done  = f_beat & f_eol & line_last & ~idle;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      FFC_IDLE: begin
        if (go_ds)      st_nxt = FFC_DSAVE;
        else if (go_dl) st_nxt = FFC_DLOAD;
        else if (go_rs) st_nxt = FFC_RSAVE;
        else if (go_rl) st_nxt = FFC_RLOAD;
        else if (go_dg) st_nxt = FFC_DGEN;
        else if (go_rg) st_nxt = FFC_RGEN;
      end
      FFC_DGEN, FFC_RGEN: begin
        if (gen_done) st_nxt = FFC_IDLE;
      end
      FFC_DSAVE, FFC_DLOAD, FFC_RSAVE, FFC_RLOAD: begin
        if (copy_last) st_nxt = FFC_IDLE;
      end
      default: st_nxt = FFC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= FFC_IDLE;
      pend_r  <= 6'h00;
      copy_r  <= '0;
      lines_r <= 10'h000;
    end else if (ce) begin
      st_r    <= st_nxt;
      // A command written as it is taken stays pending
      pend_r  <= (pend_r & ~taken) | cmd_set;
      copy_r  <= idle ? '0 : copy_r + CW'(1);
      if (go_dg || go_rg) begin
        lines_r <= 10'h000;
      end else if (gen_act && f_beat && f_eol) begin
        lines_r <= lines_r + 10'h001;
      end
    end
  end

  // ========================================================
  // Generation context, frozen while a set is learnt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_gain_r  <= 3'h0;
      roi_start_r <= '0;
      roi_width_r <= 7'h00;
      tgt_lvl_r   <= 8'h00;
    end else if (ce && idle && !go_dg && !go_rg) begin
      gen_gain_r  <= again_sel;
      roi_start_r <= roi_r[CW-1:0];
      roi_width_r <= roi_r[`FFC_ROI_WID +: 7];
      tgt_lvl_r   <= man_level;
    end
  end

  // ========================================================
  // Pixel datapath
  wire [CW-1:0] col     = f_sol ? '0 : col_r;
  wire [6:0]    roi_end = {1'b0, roi_start_r} + roi_width_r;
  wire          in_roi  = ({1'b0, col} >= {1'b0, roi_start_r}) &&
                          ({1'b0, col} < roi_end);
  wire [PW-1:0] clamped = !clamp_en ? f_data :
                          (f_data > black_r) ? f_data - black_r : '0;
  wire          dark_use = dark_valid_r & ~gen_dark;
  wire [PW-1:0] dark_w   = dark_mem[col];
  wire [PW-1:0] dsub     = !dark_use ? clamped :
                           (clamped > dark_w) ? clamped - dark_w : '0;
  wire [2*PW-1:0] prod   = dsub * gain_mem[col];
  wire [15:0]   prod_sh  = prod[`FFC_GAIN_FRAC +: 16];
  wire [PW-1:0] gained   = (|prod_sh[15:PW]) ? `FFC_PIX_MAX :
                           prod_sh[PW-1:0];
  wire          resp_use = resp_en & resp_valid_r;
  wire [PW-1:0] result   = resp_use ? gained : dsub;

  // ========================================================
  // Accumulation and value generation
  wire [PW-1:0]  sample  = gen_dark ? clamped : dsub;
  wire [`FFC_ACC_W-1:0] acc_base = (lines_r == 10'h000 || go_dg || go_rg)
                                   ? '0 : acc_mem[col];
  wire [`FFC_ACC_W-1:0] acc_sum  = acc_base + `FFC_ACC_W'(sample);
  wire [PW-1:0]  avg     = acc_sum[`FFC_LINE_SHIFT +: PW];
  wire [PW-1:0]  target  = auto_sel ? auto_max_r :
                           {tgt_lvl_r, 4'h0};
  wire [19:0]    quot    = (avg == '0) ? 20'hfffff :
                           {target, 8'h00} / {8'h00, avg};
  wire [GW-1:0]  gain_calc = (|quot[19:GW]) ? `FFC_GAIN_W'(`FFC_PIX_MAX)
                                            : quot[GW-1:0];
  wire           gen_wr  = gen_act & f_beat;
  wire [8:0]     dk_addr = {again_sel, copy_r};
  wire [8:0]     rs_addr = {slot_sel, copy_r};

  always_ff @(posedge pclk) begin
    if (ce) begin
      if (gen_wr && !line_last) begin
        acc_mem[col] <= acc_sum;
      end
      if (gen_wr && line_last && gen_dark) begin
        dark_mem[col] <= in_roi ? avg : '0;
      end else if (st_r == FFC_DLOAD) begin
        dark_mem[copy_r] <= dark_flash[dk_addr];
      end
      if (gen_wr && line_last && gen_resp) begin
        gain_mem[col] <= in_roi ? gain_calc : `FFC_GAIN_UNITY;
      end else if (st_r == FFC_RLOAD) begin
        gain_mem[copy_r] <= resp_flash[rs_addr];
      end
      if (st_r == FFC_DSAVE) begin
        dark_flash[dk_addr] <= dark_mem[copy_r];
      end
      if (st_r == FFC_RSAVE) begin
        resp_flash[rs_addr] <= gain_mem[copy_r];
      end
    end
  end

  // ========================================================
  // Line position, black level, auto target, valid flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_r        <= '0;
      ob_sum_r     <= '0;
      black_r      <= '0;
      auto_max_r   <= '0;
      dark_valid_r <= 1'b0;
      resp_valid_r <= 1'b0;
    end else if (ce) begin
      if (f_beat) begin
        col_r <= col + CW'(1);
        // Black level tracks the leading shielded pixels of each line
        if (col <= `FFC_OB_LAST) begin
          ob_sum_r <= (col == '0 ? '0 : ob_sum_r) + (PW+2)'(f_data);
        end
        if (col == `FFC_OB_LAST) begin
          black_r <= PW'((ob_sum_r + (PW+2)'(f_data)) >> `FFC_OB_SHIFT);
        end
      end
      if (go_rg) begin
        auto_max_r <= '0;
      end else if (gen_resp && f_beat && lines_r == 10'h000 && in_roi &&
                   sample > auto_max_r) begin
        auto_max_r <= sample;
      end
      if (gen_done && gen_dark) begin
        dark_valid_r <= 1'b1;
      end else if (st_r == FFC_DLOAD && copy_last) begin
        dark_valid_r <= 1'b1;
      end
      if (gen_done && gen_resp) begin
        resp_valid_r <= 1'b1;
      end else if (st_r == FFC_RLOAD && copy_last) begin
        resp_valid_r <= 1'b1;
      end
    end
  end

  // ========================================================
  // Output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_out_valid <= 1'b0;
      pix_out_data  <= '0;
      pix_out_sol   <= 1'b0;
      pix_out_eol   <= 1'b0;
    end else if (ce && f_ready) begin
      pix_out_valid <= f_valid;
      if (f_valid) begin
        pix_out_data <= result;
        pix_out_sol  <= f_sol;
        pix_out_eol  <= f_eol;
      end
    end
  end

  // ========================================================
  // Checks
  a_plain_pass: assert property (@(posedge pclk) disable iff (!presetn)
    ce && f_beat && !clamp_en && !dark_use && !resp_use
    |=> pix_out_data == $past(f_data))
    else $error("pixel altered with all corrections off");
  a_dark_count: assert property (@(posedge pclk) disable iff (!presetn)
    ce && gen_done && gen_dark |-> lines_r == `FFC_GEN_LAST)
    else $error("dark set finished before full line count");
  a_dark_ready: assert property (@(posedge pclk) disable iff (!presetn)
    ce && gen_done && gen_dark |=> dark_valid_r && idle)
    else $error("dark set not applied after generation");
  a_gain_held: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_r == FFC_DGEN |=> $stable(gen_gain_r))
    else $error("gain context moved during generation");
  a_copy_span: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == FFC_DSAVE && !copy_last |=> st_r == FFC_DSAVE)
    else $error("dark save ended early");
  a_load_valid: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dark_valid_r) |-> $past(st_r) inside {FFC_DGEN, FFC_DLOAD})
    else $error("dark valid raised without load or generation");
  a_roi_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    ce && gen_act && !idle |=> $stable(roi_start_r) && $stable(roi_width_r))
    else $error("pixel range changed during generation");
  a_resp_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(resp_valid_r) && $past(st_r) == FFC_RGEN
    |-> $past(lines_r) == `FFC_GEN_LAST)
    else $error("response set finished early");
  a_rload_len: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_r == FFC_RLOAD && copy_last |=> idle && resp_valid_r)
    else $error("response load did not complete");
  a_man_target: assert property (@(posedge pclk) disable iff (!presetn)
    !auto_sel |-> target == {tgt_lvl_r, 4'h0})
    else $error("manual target not used");
  a_slot_addr: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == FFC_RSAVE |-> rs_addr[8:CW] == slot_sel)
    else $error("response save slot mismatch");
  c_dark_gen:  cover property (@(posedge pclk) gen_done && gen_dark);
  c_resp_gen:  cover property (@(posedge pclk) gen_done && gen_resp);
  c_resp_load: cover property (@(posedge pclk)
    st_r == FFC_RLOAD && copy_last);
  c_fifo_full: cover property (@(posedge pclk) !pix_in_ready);
endmodule // ffc_top

// ### ffc_defs.svh
// Constants of the flat field correction stage
`ifndef FFC_DEFS_SVH
`define FFC_DEFS_SVH
// ==========================================================
// Pixel stream and memories
`define FFC_PIX_W        12
`define FFC_PIX_MAX      12'hfff
`define FFC_LINE_PIX     64
`define FFC_COL_W        6
`define FFC_GEN_LAST     10'h3ff
`define FFC_LINE_SHIFT   10
`define FFC_ACC_W        22
`define FFC_GAIN_W       12
`define FFC_GAIN_FRAC    8
`define FFC_GAIN_UNITY   12'h100
`define FFC_OB_LAST      6'h03
`define FFC_OB_SHIFT     2
`define FFC_FIFO_DEPTH   16
`define FFC_FIFO_AW      4
`define FFC_FLASH_WORDS  512
// ==========================================================
// Register offsets
`define FFC_REG_CTRL     8'h00
`define FFC_REG_CMD      8'h04
`define FFC_REG_ROI      8'h08
`define FFC_REG_STATUS   8'h0c
`define FFC_REG_BLACK    8'h10
// ==========================================================
// Fields and reset values
`define FFC_CTRL_CLAMP   0
`define FFC_CTRL_RESP    1
`define FFC_CTRL_AUTO    2
`define FFC_CTRL_SLOT    4
`define FFC_CTRL_TGT     8
`define FFC_CTRL_AGAIN   16
`define FFC_CTRL_MASK    32'h0007_ff77
`define FFC_CTRL_RST     32'h0000_8000
`define FFC_ROI_WID      16
`define FFC_ROI_MASK     32'h007f_003f
`define FFC_ROI_RST      32'h0040_0000
`define FFC_CMD_DGEN     0
`define FFC_CMD_DSAVE    1
`define FFC_CMD_DLOAD    2
`define FFC_CMD_RGEN     3
`define FFC_CMD_RSAVE    4
`define FFC_CMD_RLOAD    5
`endif

// ### ffc_pkg.sv
// Types of the flat field correction stage
package ffc_pkg;
  typedef enum logic [6:0] {
    FFC_IDLE  = 7'h01,
    FFC_DGEN  = 7'h02,
    FFC_RGEN  = 7'h04,
    FFC_DSAVE = 7'h08,
    FFC_DLOAD = 7'h10,
    FFC_RSAVE = 7'h20,
    FFC_RLOAD = 7'h40
  } ffc_state_e;
endpackage

// ### ffc_sensor_model.sv
// Sensor line source feeding the correction stage
`timescale 1ns/10ps
module ffc_sensor_model (
  // Clock
  input  wire logic        pclk,
  // Line stream to the stage
  output logic [11:0]      pix_in_data,
  output logic             pix_in_sol,
  output logic             pix_in_eol,
  output logic             pix_in_valid,
  input  wire logic        pix_in_ready
);
  logic busy;
  initial begin
    busy = 1'b0;
    pix_in_data = 12'h000;
    pix_in_sol = 1'b0;
    pix_in_eol = 1'b0;
    pix_in_valid = 1'b0;
  end
  // Idle data keeps moving so a stale beat is never mistaken for a new one
  always @(posedge pclk) begin
    if (!busy) pix_in_data <= ~pix_in_data;
  end
  // Eight pixel line: four black pixels, then four scene pixels
  task automatic send_line(input logic [11:0] blk, input logic [11:0] base);
    int i;
    busy = 1'b1;
    @(posedge pclk);
    for (i = 0; i < 8; i++) begin
      pix_in_valid <= 1'b1;
      pix_in_sol <= (i == 0);
      pix_in_eol <= (i == 7);
      pix_in_data <= (i < 4) ? blk : base;
      @(posedge pclk);
      while (pix_in_ready !== 1'b1) @(posedge pclk);
    end
    pix_in_valid <= 1'b0;
    pix_in_sol <= 1'b0;
    pix_in_eol <= 1'b0;
    busy = 1'b0;
  endtask
endmodule // ffc_sensor_model

// ### ffc_top_tb.sv
// Self-checking bench of the flat field correction stage
`timescale 1ns/10ps
module ffc_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pix_out_ready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq;
  logic        pready, pslverr, re, ce;
  logic [11:0] pix_in_data, pix_out_data;
  logic        pix_in_sol, pix_in_eol, pix_in_valid, pix_in_ready;
  logic        pix_out_sol, pix_out_eol, pix_out_valid;
  logic [11:0] outq[$];
  int          bad_count, num_checks, n;

  ffc_top i_ffc_top (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_in_data(pix_in_data), .pix_in_sol(pix_in_sol),
    .pix_in_eol(pix_in_eol), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .pix_out_data(pix_out_data),
    .pix_out_sol(pix_out_sol), .pix_out_eol(pix_out_eol),
    .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready));
  ffc_sensor_model i_ffc_sensor_model (.pclk(pclk),
    .pix_in_data(pix_in_data), .pix_in_sol(pix_in_sol),
    .pix_in_eol(pix_in_eol), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready));

  // ==========================================================
  // Clock, sink and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (pix_out_valid && pix_out_ready) outq.push_back(pix_out_data);
  end
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    summarize();
  end

  // ==========================================================
  // Access and compare tasks
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pix(input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR pixel expected %h seen %h", e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg("prdata", e, rq);
  endtask
  // Pixels before first are not judged
  task automatic take_line(input logic [11:0] lo, input logic [11:0] hi,
                           input int first);
    int i;
    n = 0;
    while (outq.size() < 8 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    for (i = 0; i < 8; i++) begin
      if (outq.size() == 0) chk_pix(lo, 12'hxxx);
      else if (i >= first) chk_pix((i < 4) ? lo : hi, outq.pop_front());
      else void'(outq.pop_front());
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic summarize;
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; pix_out_ready = 1'b1; ce = 1'b1;
    bad_count = 0; num_checks = 0;
    do_reset();
    rd(8'h00, 32'h0000_8000);
    rd(8'h08, 32'h0040_0000);
    rd(8'h0c, 32'h0000_0002);
    rd(8'h04, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    chk_reg("pslverr", 32'h1, {31'h0, re});
    apb(1'b1, 8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0007_ff77);
    apb(1'b1, 8'h00, 32'h0000_8002);
    i_ffc_sensor_model.send_line(12'h028, 12'h08c);
    take_line(12'h028, 12'h08c, 0);
    // Clamp on with the far end stalled until the FIFO refuses
    apb(1'b1, 8'h00, 32'h0000_8001);
    pix_out_ready <= 1'b0;
    fork
      repeat (3) i_ffc_sensor_model.send_line(12'h028, 12'h08c);
    join_none
    n = 0;
    while (pix_in_ready !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk_reg("in_ready", 32'h0, {31'h0, pix_in_ready});
    pix_out_ready <= 1'b1;
    repeat (3) take_line(12'h000, 12'h064, 3);
    wait fork;
    rd(8'h10, 32'h0000_0028);
    // Dark offsets learned over an eight pixel window
    apb(1'b1, 8'h00, 32'h0000_8000);
    apb(1'b1, 8'h08, 32'h0008_0000);
    // Access only completes once the clock enable is back
    ce <= 1'b0;
    fork
      begin
        repeat (6) @(posedge pclk);
        ce <= 1'b1;
      end
    join_none
    rd(8'h08, 32'h0008_0000);
    chk_reg("ce_hold", 32'h1, {31'h0, ce});
    apb(1'b1, 8'h04, 32'h0000_0001);
    repeat (1023) i_ffc_sensor_model.send_line(12'h014, 12'h014);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk_reg("dark_valid", 32'h0, {31'h0, rq[8]});
    i_ffc_sensor_model.send_line(12'h014, 12'h014);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk_reg("dark_valid", 32'h1, {31'h0, rq[8]});
    chk_reg("gain_idx", 32'h0, {29'h0, rq[22:20]});
    outq.delete();
    i_ffc_sensor_model.send_line(12'h078, 12'h078);
    take_line(12'h064, 12'h064, 0);
    // Saved set survives a reset, volatile set does not
    apb(1'b1, 8'h04, 32'h0000_0002);
    repeat (80) @(posedge pclk);
    do_reset();
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk_reg("dark_valid", 32'h0, {31'h0, rq[8]});
    i_ffc_sensor_model.send_line(12'h078, 12'h078);
    take_line(12'h078, 12'h078, 0);
    apb(1'b1, 8'h04, 32'h0000_0004);
    repeat (80) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk_reg("dark_valid", 32'h1, {31'h0, rq[8]});
    i_ffc_sensor_model.send_line(12'h078, 12'h078);
    take_line(12'h064, 12'h064, 0);
    // Response gains toward a manual target of 100, kept in slot 3
    apb(1'b1, 8'h00, 32'h0000_6432);
    apb(1'b1, 8'h04, 32'h0000_0008);
    repeat (1023) i_ffc_sensor_model.send_line(12'h814, 12'h814);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk_reg("resp_valid", 32'h0, {31'h0, rq[9]});
    i_ffc_sensor_model.send_line(12'h814, 12'h814);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk_reg("resp_valid", 32'h1, {31'h0, rq[9]});
    outq.delete();
    i_ffc_sensor_model.send_line(12'h814, 12'h814);
    take_line(12'h640, 12'h640, 0);
    apb(1'b1, 8'h04, 32'h0000_0010);
    repeat (80) @(posedge pclk);
    // Auto target is the flat level itself, so gains come out unity
    apb(1'b1, 8'h00, 32'h0000_6436);
    apb(1'b1, 8'h04, 32'h0000_0008);
    repeat (1024) i_ffc_sensor_model.send_line(12'h814, 12'h814);
    repeat (8) @(posedge pclk);
    outq.delete();
    i_ffc_sensor_model.send_line(12'h814, 12'h814);
    take_line(12'h800, 12'h800, 0);
    apb(1'b1, 8'h04, 32'h0000_0020);
    repeat (80) @(posedge pclk);
    i_ffc_sensor_model.send_line(12'h814, 12'h814);
    take_line(12'h640, 12'h640, 0);
    apb(1'b1, 8'h00, 32'h0000_6430);
    i_ffc_sensor_model.send_line(12'h814, 12'h814);
    take_line(12'h800, 12'h800, 0);
    summarize();
  end
endmodule // ffc_top_tb
